//--- verilog/see_pkg.sv
// shared constants and types for the two-wire serial eeprom target
// assumes a 50 MHz system clock and a bus controller that owns scl
package see_pkg;

	// system clock and internal write timing
	localparam int CLK_HZ = 50_000_000;
	localparam int WR_TIME_MS = 5;
	// longest time, so rounded down
	localparam int WR_CYCLES = WR_TIME_MS * (CLK_HZ / 1000);
	localparam int TMR_W = 18;

	// array geometry
	localparam int ADDR_W_SMALL = 12;
	localparam int ADDR_W_LARGE = 13;
	localparam int PAGE_BYTES = 32;
	localparam int PAGE_W = 5;
	localparam int CIDX_W = 6;

	// device address word layout
	localparam logic [3:0] FAMILY_CODE = 4'hA;
	localparam int FAMILY_LSB = 4;
	localparam int SEL_LSB = 1;
	localparam int DIR_BIT = 0;

	// bit counter values within one word plus acknowledge
	localparam logic [3:0] LAST_DATA_BIT = 4'h7;
	localparam logic [3:0] ACK_SLOT = 4'h8;

	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_DEV = 7'h02,
		ST_AHI = 7'h04,
		ST_ALO = 7'h08,
		ST_DATA = 7'h10,
		ST_SKIP = 7'h20,
		ST_BUSY = 7'h40
	} see_st_e;

	// scl-domain sampler state
	typedef struct packed {
		logic bit_v;
		logic tog;
	} see_link_s;

	// system-domain state
	typedef struct packed {
		see_st_e st;
		logic [2:0] scl_s;
		logic [2:0] sda_s;
		logic [2:0] tog_s;
		logic [1:0][2:0] sel_s;
		logic [1:0] wp_s;
		logic [3:0] bitcnt;
		logic [7:0] sh;
		logic ack;
		logic oe;
		logic [15:0] addr;
		logic [PAGE_BYTES-1:0][7:0] page;
		logic [PAGE_BYTES-1:0] vld;
		logic [TMR_W-1:0] tmr;
		logic [CIDX_W-1:0] cidx;
		logic busy;
		logic stby;
	} see_state_s;

	localparam logic [TMR_W-1:0] TMR_RST = 18'h00000;
	localparam logic [15:0] ADDR_RST = 16'h0000;

endpackage

//--- verilog/see_top.sv
// two-wire serial eeprom target: addressing, byte/page write, timed commit
// assumes sda is open drain with an external pull-up; scl runs only in frames
//
// Contract
// RULE_01: small variant: 128 pages, 12-bit address
// RULE_02: large variant: 256 pages, 13-bit address
// RULE_03: data changes only while clock low
// RULE_04: data falling, clock high: start
// RULE_05: data rising, clock high: stop
// RULE_06: 8-bit words, acknowledge on ninth clock
// RULE_07: standby at power-up and after stop
// RULE_08: controller recovers bus with nine clocks
// RULE_09: controller sends device address after start
// RULE_10: upper four bits must be 1010
// RULE_11: next three bits match select pins
// RULE_12: last address bit selects read/write
// RULE_13: match acknowledges; mismatch returns to standby
// RULE_14: byte write; stop starts internal write
// RULE_15: internal write lasts at most 5 ms
// RULE_16: busy device ignores bus, no acknowledge
// RULE_17: page write of up to 32 bytes
// RULE_18: only low five address bits increment
// RULE_19: polling acknowledged only after write completes
// RULE_20: write-protect high blocks all array writes
// RULE_21: sample on scl rise, shift on fall
// RULE_22: word address two bytes, high first
// RULE_23: own timer ends write, releases bus
`timescale 1ns/1ps

module see_top #(
	parameter int ADDR_W = see_pkg::ADDR_W_LARGE,
	parameter int WR_CYCLES = see_pkg::WR_CYCLES
) (
	// system clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// two-wire bus
	input wire logic scl,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	// straps and protection
	input wire logic [2:0] device_select_pins,
	input wire logic wp,
	// array inspection port
	input wire logic [ADDR_W-1:0] rd_addr,
	output logic [7:0] rd_data,
	// status
	output logic busy,
	output logic standby
);

	localparam int DEPTH = 1 << ADDR_W; // [RULE_01] [RULE_02]

	see_pkg::see_link_s lk_q;
	see_pkg::see_link_s lk_d;
	see_pkg::see_state_s q;
	see_pkg::see_state_s d;

	logic [7:0] mem [DEPTH];
	logic [7:0] rd_q;
	logic sda_q;

	logic start_c;
	logic stop_c;
	logic fall_c;
	logic bit_ev_c;
	logic [7:0] byte_c;
	logic match_c;
	logic commit_c;
	logic [ADDR_W-1:0] waddr_c;

	// scl domain: one sample per rising edge, announced by a toggle
	always_comb begin
		lk_d.bit_v = sda_i; // [RULE_21]
		lk_d.tog = ~lk_q.tog;
	end

	always_ff @(posedge scl or negedge arst_n) begin
		if (!arst_n) begin
			lk_q <= '0;
		end else begin
			lk_q <= lk_d;
		end
	end

	// conditions seen on synchronised pins; index 1 is now, 2 is before
	always_comb begin
		start_c = q.scl_s[1] && q.scl_s[2] && q.sda_s[2] && !q.sda_s[1]; // [RULE_04]
		stop_c = q.scl_s[1] && q.scl_s[2] && !q.sda_s[2] && q.sda_s[1]; // [RULE_05]
		fall_c = q.scl_s[2] && !q.scl_s[1];
		bit_ev_c = q.tog_s[2] ^ q.tog_s[1];
		// bit_v is stable for a whole scl period after its toggle lands
		byte_c = {q.sh[6:0], lk_q.bit_v};
		match_c = (byte_c[7:see_pkg::FAMILY_LSB] == see_pkg::FAMILY_CODE) // [RULE_10]
			&& (byte_c[see_pkg::SEL_LSB +: 3] == q.sel_s[1]); // [RULE_11]
		commit_c = (q.st == see_pkg::ST_BUSY) && !q.cidx[see_pkg::PAGE_W]
			&& q.vld[q.cidx[see_pkg::PAGE_W-1:0]];
		waddr_c = {q.addr[ADDR_W-1:see_pkg::PAGE_W],
			q.cidx[see_pkg::PAGE_W-1:0]};
	end

	always_comb begin
		d = q;
		d.scl_s = {q.scl_s[1:0], scl};
		d.sda_s = {q.sda_s[1:0], sda_i};
		d.tog_s = {q.tog_s[1:0], lk_q.tog};
		d.sel_s = {q.sel_s[0], device_select_pins};
		d.wp_s = {q.wp_s[0], wp};
		case (q.st)
			see_pkg::ST_BUSY: begin
				// bus inputs have no effect until the timer runs out
				d.oe = 1'b0; // [RULE_16] [RULE_19]
				if (!q.cidx[see_pkg::PAGE_W]) begin
					d.cidx = q.cidx + 1'b1;
				end
				if (q.tmr <= see_pkg::TMR_W'(1)) begin
					d.st = see_pkg::ST_IDLE; // [RULE_23] [RULE_07]
					d.tmr = see_pkg::TMR_RST;
				end else begin
					d.tmr = q.tmr - 1'b1; // [RULE_15]
				end
			end
			see_pkg::ST_IDLE, see_pkg::ST_DEV, see_pkg::ST_AHI,
			see_pkg::ST_ALO, see_pkg::ST_DATA, see_pkg::ST_SKIP: begin
				if (start_c) begin
					d.st = see_pkg::ST_DEV; // [RULE_04]
					d.bitcnt = 4'h0;
					d.ack = 1'b0;
					d.oe = 1'b0;
				end else if (stop_c) begin
					d.bitcnt = 4'h0;
					d.ack = 1'b0;
					d.oe = 1'b0;
					// protected array: data is dropped, no write cycle
					if (q.st == see_pkg::ST_DATA && |q.vld && !q.wp_s[1]) begin
						d.st = see_pkg::ST_BUSY; // [RULE_14] [RULE_20]
						d.tmr = see_pkg::TMR_W'(WR_CYCLES);
						d.cidx = '0;
					end else begin
						d.st = see_pkg::ST_IDLE; // [RULE_05] [RULE_07]
					end
				end else begin
					if (fall_c) begin
						// drive low from fall after bit 8 to fall after ack
						d.oe = (q.bitcnt == see_pkg::ACK_SLOT) && q.ack; // [RULE_06] [RULE_21]
					end
					if (bit_ev_c && q.st != see_pkg::ST_IDLE) begin
						if (q.bitcnt == see_pkg::ACK_SLOT) begin
							d.bitcnt = 4'h0;
						end else begin
							d.sh = byte_c; // [RULE_03]
							d.bitcnt = q.bitcnt + 1'b1;
						end
						if (q.bitcnt == see_pkg::LAST_DATA_BIT) begin
							d.ack = 1'b1; // [RULE_06]
							case (q.st)
								see_pkg::ST_DEV: begin
									if (!match_c) begin
										d.ack = 1'b0;
										d.st = see_pkg::ST_IDLE; // [RULE_13]
									end else if (byte_c[see_pkg::DIR_BIT]) begin
										d.st = see_pkg::ST_SKIP; // [RULE_12]
									end else begin
										d.st = see_pkg::ST_AHI; // [RULE_12] [RULE_13]
									end
								end
								see_pkg::ST_AHI: begin
									d.addr[15:8] = byte_c; // [RULE_22]
									d.st = see_pkg::ST_ALO;
								end
								see_pkg::ST_ALO: begin
									d.addr[7:0] = byte_c; // [RULE_22]
									d.vld = '0;
									d.st = see_pkg::ST_DATA;
								end
								see_pkg::ST_DATA: begin
									d.page[q.addr[see_pkg::PAGE_W-1:0]] = byte_c; // [RULE_17]
									d.vld[q.addr[see_pkg::PAGE_W-1:0]] = 1'b1;
									// page bits stay; a 33rd byte overwrites the first
									d.addr[see_pkg::PAGE_W-1:0] =
										q.addr[see_pkg::PAGE_W-1:0] + 1'b1; // [RULE_18]
								end
								default: begin
									d.ack = 1'b0;
								end
							endcase
						end
					end
				end
			end
			default: begin
				d.st = see_pkg::ST_IDLE;
				d.oe = 1'b0;
			end
		endcase
		d.busy = (d.st == see_pkg::ST_BUSY);
		d.stby = (d.st == see_pkg::ST_IDLE);
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			q <= '0;
			q.st <= see_pkg::ST_IDLE; // [RULE_07]
			q.scl_s <= 3'h7;
			q.sda_s <= 3'h7;
			q.addr <= see_pkg::ADDR_RST;
			q.tmr <= see_pkg::TMR_RST;
			q.stby <= 1'b1;
			sda_q <= 1'b0;
		end else begin
			q <= d;
			sda_q <= 1'b0;
		end
	end

	// array: no reset, written one staged byte per cycle during the timer
	always_ff @(posedge clk) begin
		if (commit_c) begin
			mem[waddr_c] <= q.page[q.cidx[see_pkg::PAGE_W-1:0]]; // [RULE_18]
		end
		rd_q <= mem[rd_addr];
	end

	assign sda_o = sda_q;
	assign sda_oe = q.oe;
	assign rd_data = rd_q;
	assign busy = q.busy;
	assign standby = q.stby;

endmodule // see_top

//--- test/see_properties.sv
// port checker for the eeprom target
// assumes bind in the bench; one clock domain
`timescale 1ns/1ps
module see_properties #(
	parameter int ADDR_W = 13,
	parameter int WR_CYCLES = 200
) (
	// clock
	input wire logic clk,
	input wire logic arst_n,
	// bus
	input wire logic scl,
	input wire logic sda_i,
	input wire logic sda_o,
	input wire logic sda_oe,
	// pins
	input wire logic [2:0] device_select_pins,
	input wire logic wp,
	input wire logic [ADDR_W-1:0] rd_addr,
	input wire logic [7:0] rd_data,
	input wire logic busy,
	input wire logic standby
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	logic [17:0] cnt_q;
	// counter, not repetition: the write spans WR_CYCLES cycles, a thousand in the bench
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			cnt_q <= 18'h00000;
		else
			cnt_q <= busy ? cnt_q + 18'h00001 : 18'h00000;
	end
	sequence ack_up_s;
		!sda_oe ##1 sda_oe;
	endsequence
	oe_busy_a: assert property (busy |-> !sda_oe)
		else $error("ack while busy");
	busy_stby_a: assert property (busy |-> !standby)
		else $error("standby while busy");
	wr_max_a: assert property (cnt_q <= WR_CYCLES + 1)
		else $error("write too long");
	wr_min_a: assert property ($fell(busy) |-> cnt_q >= WR_CYCLES - 1)
		else $error("write too short");
	done_stby_a: assert property ($fell(busy) |-> ##[0:1] standby)
		else $error("no standby after write");
	ack_edge_a: assert property ($changed(sda_oe) |-> !scl)
		else $error("sda moved with scl high");
	ack_hold_a: assert property (ack_up_s |-> sda_oe[*8])
		else $error("ack too short");
	wp_block_a: assert property ($rose(busy) |-> !wp)
		else $error("write under protect");
endmodule // see_properties

//--- test/see_ctrl.sv
// two-wire bus controller model; scl stands still between frames
// assumes a pull-up on sda; phase unrelated to the system clock
`timescale 1ns/1ps
module see_ctrl #(
	parameter int H = 435
) (
	// bus
	output logic scl,
	output logic sda_low,
	input wire logic sda
);
	event got;
	logic ackb;
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
		ackb = 1'b0;
	end
	task automatic bitx(input logic b);
		#(H/2) sda_low = !b;
		#(H/2) scl = 1'b1;
		#H ackb = !sda;
		scl = 1'b0;
	endtask
	task automatic start();
		#(H/2) sda_low = 1'b0;
		#(H/2) scl = 1'b1;
		#H sda_low = 1'b1;
		#H scl = 1'b0;
	endtask
	task automatic stop();
		#(H/2) sda_low = 1'b1;
		#(H/2) scl = 1'b1;
		#H sda_low = 1'b0;
		#H;
	endtask
	task automatic wbyte(input logic [7:0] d);
		for (int i = 7; i >= 0; i--)
			bitx(d[i]);
		bitx(1'b1);
		->got;
	endtask
endmodule // see_ctrl

//--- test/see_top_bench.sv
// self-checking bench for the eeprom target
// assumes see_ctrl as controller and the bound port checker
`timescale 1ns/1ps
module see_top_bench;
	logic clk = 1'b0, arst_n = 1'b0, wp = 1'b0;
	logic scl, sda_low, sda_oe, busy, stby;
	logic [2:0] sel = 3'h0;
	logic [12:0] rd_addr = 13'h0000;
	logic [7:0] rd_data, mem [32];
	logic [7:0] qd [$];
	logic qa [$];
	int error_cnt = 0, num_checks = 0, seed = 32'h4AB5;
	wire sda = !(sda_low || sda_oe);
	always #10 clk = !clk;
	see_top #(.ADDR_W(13), .WR_CYCLES(1000)) i_see_top (.clk(clk),
		.arst_n(arst_n), .scl(scl), .sda_i(sda), .sda_o(), .sda_oe(sda_oe),
		.device_select_pins(sel), .wp(wp), .rd_addr(rd_addr),
		.rd_data(rd_data), .busy(busy), .standby(stby));
	see_ctrl i_see_ctrl (.scl(scl), .sda_low(sda_low), .sda(sda));
	task automatic chk(input string n, input logic [7:0] e, s);
		num_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("CHECK FAILED %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic cmp_ack(input logic e, s);
		chk("ack", {7'h00, e}, {7'h00, s});
	endtask
	task automatic cmp_byte(input logic [7:0] e, s);
		chk("array", e, s);
	endtask
	always @(i_see_ctrl.got)
		cmp_ack(qa.pop_front(), i_see_ctrl.ackb);
	always @(rd_addr) begin
		repeat (2) @(posedge clk);
		cmp_byte(qd.pop_front(), rd_data);
	end
	task automatic xfer(input logic [7:0] dw, input logic a);
		qa.push_back(a);
		i_see_ctrl.start();
		i_see_ctrl.wbyte(dw);
	endtask
	task automatic wr(input logic [7:0] d);
		qa.push_back(1'b1);
		i_see_ctrl.wbyte(d);
	endtask
	task automatic look(input logic [12:0] a, input logic [7:0] e);
		qd.push_back(e);
		@(posedge clk);
		#1 rd_addr = a;
		repeat (3) @(posedge clk);
	endtask
	task automatic final_report();
		if (error_cnt == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		#1ms error_cnt++;
		final_report();
	end
	initial begin
		sel = 3'($random(seed));
		repeat (5) @(posedge clk);
		#1 arst_n = 1'b1;
		repeat (6) @(posedge clk);
		xfer({4'h5, sel, 1'b0}, 1'b0);
		i_see_ctrl.stop();
		xfer({4'hA, ~sel, 1'b0}, 1'b0);
		i_see_ctrl.stop();
		xfer({4'hA, sel, 1'b1}, 1'b1);
		i_see_ctrl.stop();
		// upper address bits set: must be dropped
		xfer({4'hA, sel, 1'b0}, 1'b1);
		wr(8'hE3);
		wr(8'hFE);
		for (int i = 0; i < 34; i++) begin
			mem[(30 + i) % 32] = 8'($random(seed));
			wr(mem[(30 + i) % 32]);
		end
		i_see_ctrl.stop();
		xfer({4'hA, sel, 1'b0}, 1'b0);
		i_see_ctrl.stop();
		wait (busy === 1'b0);
		repeat (2) @(posedge clk);
		chk("standby", 8'h01, {7'h00, stby});
		xfer({4'hA, sel, 1'b0}, 1'b1);
		i_see_ctrl.stop();
		for (int i = 0; i < 32; i++)
			look(13'h03E0 + 13'(i), mem[i]);
		#1 wp = 1'b1;
		xfer({4'hA, sel, 1'b0}, 1'b1);
		wr(8'h03);
		wr(8'hE5);
		wr(~mem[5]);
		i_see_ctrl.stop();
		repeat (20) @(posedge clk);
		chk("busy", 8'h00, {7'h00, busy});
		chk("standby", 8'h01, {7'h00, stby});
		look(13'h03E5, mem[5]);
		final_report();
	end
endmodule // see_top_bench
bind see_top see_properties #(.ADDR_W(ADDR_W), .WR_CYCLES(WR_CYCLES))
	i_see_properties (.clk(clk), .arst_n(arst_n), .scl(scl), .sda_i(sda_i),
	.sda_o(sda_o), .sda_oe(sda_oe), .device_select_pins(device_select_pins),
	.wp(wp), .rd_addr(rd_addr), .rd_data(rd_data), .busy(busy),
	.standby(standby));
